/* pkg/slsc_pkg.sv */
// Purpose: constants and types for the serial link sync control block
// Assumes: one 10 MHz clock, asynchronous active-low reset
// Notes: sync request pins are asynchronous and pass two flip-flops
// Contract
// (R1) Single-ended request is active low; used when select bit is 0.
// (R2) Request mechanism applies to link initialisation in 8B/10B modes only.
// (R3) Request low starts code group synchronisation on the lanes.
// (R4) Receiver releases request high; device then sends initial lane alignment.
// (R5) Select bit 1 takes the request from the differential timestamp pair.
// (R6) Receiver holds single-ended request at ground when pair is used.
// (R7) Power-down high disables analog circuits and all serializer outputs.
// (R8) Controller keeps power-down low normally; not a power-saving control.
// (R9) Asynchronous request is synchronised before any level change is acted on.
package slsc_pkg;

  // ---------------------------------------------------------------
  // link states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    slsc_idle,
    slsc_cgs,
    slsc_ilas,
    slsc_data
  } slsc_state_e;

  // ---------------------------------------------------------------
  // constants
  // ---------------------------------------------------------------
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [7:0] ILAS_LEN_RESET = 8'h10;
  localparam logic [1:0] SYNC_RESET = 2'h3;

  // ---------------------------------------------------------------
  // link status carrier
  // ---------------------------------------------------------------
  typedef struct packed {
    logic cgs_active;
    logic ilas_active;
    logic data_active;
    logic lanes_enable;
  } slsc_status_s;

endpackage

/* logic/slsc_top.sv */
// Purpose: link initialisation control from the receiver's sync request
// Assumes: sync pins and power-down are asynchronous to clock
// Notes: ilas length counts clock cycles of the alignment sequence
`timescale 1ns/1ns
`default_nettype none
module slsc_top #(
  parameter logic [7:0] ILAS_LEN = slsc_pkg::ILAS_LEN_RESET
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // configuration
  input wire logic sync_select,
  input wire logic enc_8b10b,
  // pins
  input wire logic single_ended_sync_request_n,
  input wire logic timestamp_diff_pair_sync_n,
  input wire logic power_down_pin,
  // status
  output var slsc_pkg::slsc_status_s status,
  output logic analog_enable
);

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic [1:0] se_sync;
  logic [1:0] td_sync;
  logic [1:0] pd_sync;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      se_sync <= slsc_pkg::SYNC_RESET;
      td_sync <= slsc_pkg::SYNC_RESET;
      pd_sync <= 2'h0;
    end else begin
      se_sync <= {se_sync[0], single_ended_sync_request_n}; // [R9]
      td_sync <= {td_sync[0], timestamp_diff_pair_sync_n}; // [R9]
      pd_sync <= {pd_sync[0], power_down_pin};
    end
  end

  // ---------------------------------------------------------------
  // request selection
  // ---------------------------------------------------------------
  wire logic req_n;
  wire logic power_down;
  assign req_n = sync_select ? td_sync[1] : se_sync[1]; // [R1] [R5]
  assign power_down = pd_sync[1];

  // ---------------------------------------------------------------
  // link state machine
  // ---------------------------------------------------------------
  slsc_pkg::slsc_state_e state;
  slsc_pkg::slsc_state_e next_state;
  logic [7:0] ilas_count;
  logic [7:0] next_ilas_count;

  always_comb begin
    next_state = state;
    next_ilas_count = ilas_count;
    case (state)
      slsc_pkg::slsc_idle: begin
        if (enc_8b10b && !req_n) begin
          next_state = slsc_pkg::slsc_cgs; // [R2] [R3]
        end
      end
      slsc_pkg::slsc_cgs: begin
        if (req_n) begin
          next_state = slsc_pkg::slsc_ilas; // [R4]
          next_ilas_count = 8'h00;
        end
      end
      slsc_pkg::slsc_ilas: begin
        if (!req_n) begin
          next_state = slsc_pkg::slsc_cgs; // [R3]
        end else if (ilas_count == ILAS_LEN - 8'h01) begin
          next_state = slsc_pkg::slsc_data;
        end else begin
          next_ilas_count = ilas_count + 8'h01;
        end
      end
      slsc_pkg::slsc_data: begin
        if (!req_n) begin
          next_state = slsc_pkg::slsc_cgs; // [R3]
        end
      end
      default: next_state = slsc_pkg::slsc_idle;
    endcase
    if (power_down || !enc_8b10b) begin
      next_state = slsc_pkg::slsc_idle; // [R7] [R2]
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= slsc_pkg::slsc_idle;
      ilas_count <= 8'h00;
    end else begin
      state <= next_state;
      ilas_count <= next_ilas_count;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  slsc_pkg::slsc_status_s next_status;
  assign next_status.cgs_active = (next_state == slsc_pkg::slsc_cgs);
  assign next_status.ilas_active = (next_state == slsc_pkg::slsc_ilas);
  assign next_status.data_active = (next_state == slsc_pkg::slsc_data);
  assign next_status.lanes_enable = !power_down; // [R7]

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status <= '0;
      analog_enable <= 1'b0;
    end else begin
      status <= next_status;
      analog_enable <= !power_down; // [R7]
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // request low seen through the selected synchroniser
  sequence s_req_low;
    !req_n && enc_8b10b && !power_down;
  endsequence

  // request released while code group sync runs
  sequence s_cgs_release;
    state == slsc_pkg::slsc_cgs && req_n && enc_8b10b && !power_down;
  endsequence

  // alignment sequence still counting
  sequence s_ilas_step;
    state == slsc_pkg::slsc_ilas && ilas_count != ILAS_LEN - 8'h01 && req_n && enc_8b10b && !power_down;
  endsequence

  // last cycle of the alignment sequence
  sequence s_ilas_last;
    state == slsc_pkg::slsc_ilas && ilas_count == ILAS_LEN - 8'h01 && req_n && enc_8b10b && !power_down;
  endsequence

  // code group sync
  a_cgs_on_low: assert property (@(posedge clock) disable iff (!resetn) // [R3]
    s_req_low |=> state == slsc_pkg::slsc_cgs && status.cgs_active)
    else $error("request low did not start code group sync");
  a_data_restart: assert property (@(posedge clock) disable iff (!resetn) // [R3]
    (state == slsc_pkg::slsc_data && !req_n && enc_8b10b && !power_down) |=> state == slsc_pkg::slsc_cgs)
    else $error("request low in data did not restart code group sync");
  a_idle_wait: assert property (@(posedge clock) disable iff (!resetn) // [R3]
    (state == slsc_pkg::slsc_idle && req_n) |=> state == slsc_pkg::slsc_idle)
    else $error("link left idle without a request");

  // lane alignment
  a_ilas_on_high: assert property (@(posedge clock) disable iff (!resetn) // [R4]
    s_cgs_release |=> state == slsc_pkg::slsc_ilas && status.ilas_active && ilas_count == 8'h00)
    else $error("release did not start lane alignment");
  a_ilas_counting: assert property (@(posedge clock) disable iff (!resetn) // [R4]
    s_ilas_step |=> state == slsc_pkg::slsc_ilas && ilas_count == $past(ilas_count) + 8'h01)
    else $error("lane alignment left early or miscounted");
  a_ilas_length: assert property (@(posedge clock) disable iff (!resetn) // [R4]
    s_ilas_last |=> state == slsc_pkg::slsc_data && status.data_active)
    else $error("alignment sequence length wrong");
  a_ilas_from_cgs: assert property (@(posedge clock) disable iff (!resetn) // [R4]
    $rose(status.ilas_active) |-> $past(state) == slsc_pkg::slsc_cgs)
    else $error("lane alignment entered without code group sync");
  a_data_from_ilas: assert property (@(posedge clock) disable iff (!resetn) // [R4]
    $rose(status.data_active) |-> $past(state) == slsc_pkg::slsc_ilas)
    else $error("data entered without lane alignment");

  // power-down
  a_pd_lanes_off: assert property (@(posedge clock) disable iff (!resetn) // [R7]
    power_down |=> !status.lanes_enable && !analog_enable && state == slsc_pkg::slsc_idle)
    else $error("power-down did not disable lanes");
  a_pd_blocks_req: assert property (@(posedge clock) disable iff (!resetn) // [R7]
    (power_down && !req_n) |=> !status.cgs_active && !status.ilas_active && !status.data_active)
    else $error("request acted on during power-down");
  a_pd_release: assert property (@(posedge clock) disable iff (!resetn) // [R7]
    (resetn && !power_down) |=> status.lanes_enable && analog_enable)
    else $error("lanes stayed off without power-down");

  // request source selection
  a_select_se: assert property (@(posedge clock) disable iff (!resetn) // [R1]
    (!sync_select && !se_sync[1] && enc_8b10b && !power_down) |=> state == slsc_pkg::slsc_cgs)
    else $error("single-ended request not selected");
  a_se_only: assert property (@(posedge clock) disable iff (!resetn) // [R1]
    (!sync_select && se_sync[1] && state == slsc_pkg::slsc_idle) |=> state == slsc_pkg::slsc_idle)
    else $error("pair request acted on while single-ended selected");
  a_select_pair: assert property (@(posedge clock) disable iff (!resetn) // [R5]
    (sync_select && !td_sync[1] && enc_8b10b && !power_down) |=> state == slsc_pkg::slsc_cgs)
    else $error("pair request not selected");
  a_pair_only: assert property (@(posedge clock) disable iff (!resetn) // [R5]
    (sync_select && td_sync[1] && state == slsc_pkg::slsc_idle) |=> state == slsc_pkg::slsc_idle)
    else $error("single-ended request acted on while pair selected");

  // line coding mode
  a_no_8b10b_idle: assert property (@(posedge clock) disable iff (!resetn) // [R2]
    !enc_8b10b |=> state == slsc_pkg::slsc_idle)
    else $error("link left idle outside 8b10b mode");
  a_no_8b10b_quiet: assert property (@(posedge clock) disable iff (!resetn) // [R2]
    !enc_8b10b |=> !status.cgs_active && !status.ilas_active && !status.data_active)
    else $error("link phase shown outside 8b10b mode");

  // synchronisers
  a_sync_delay: assert property (@(posedge clock) disable iff (!resetn) // [R9]
    $fell(se_sync[1]) |-> $past(single_ended_sync_request_n, 2) == 1'b0)
    else $error("synchroniser depth wrong");
  a_sync_rise: assert property (@(posedge clock) disable iff (!resetn) // [R9]
    $rose(se_sync[1]) |-> $past(single_ended_sync_request_n, 2) == 1'b1)
    else $error("single-ended release depth wrong");
  a_pair_sync_delay: assert property (@(posedge clock) disable iff (!resetn) // [R9]
    $fell(td_sync[1]) |-> $past(timestamp_diff_pair_sync_n, 2) == 1'b0)
    else $error("pair synchroniser depth wrong");
  a_pair_rise: assert property (@(posedge clock) disable iff (!resetn) // [R9]
    $rose(td_sync[1]) |-> $past(timestamp_diff_pair_sync_n, 2) == 1'b1)
    else $error("pair release depth wrong");
  a_pd_rise: assert property (@(posedge clock) disable iff (!resetn) // [R7]
    $rose(pd_sync[1]) |-> $past(power_down_pin, 2) == 1'b1)
    else $error("power-down synchroniser depth wrong");

endmodule
`default_nettype wire

/* test/slsc_rx_model.sv */
// Purpose: receiver side that drives the sync request pins
// Assumes: req is a level set by the bench, high asks for sync
// Notes: the single-ended pin is held at ground when not in use; the unused pair pin is held high
`timescale 1ns/1ns
`default_nettype none
module slsc_rx_model (
  // control
  input wire logic sel,
  input wire logic req,
  // pins
  output logic se_n,
  output logic ts_n
);
  assign se_n = sel ? 1'h0 : ~req;
  assign ts_n = sel ? ~req : 1'h1;
endmodule
`default_nettype wire

/* test/serial_link_sync_control_test.sv */
// Purpose: self-checking bench for the sync control block
// Assumes: ilas length set to 4 cycles
// Notes: pins pass two sync flops, so results land on the third edge
`timescale 1ns/1ns
`default_nettype none
module serial_link_sync_control_test;
  logic clock = 1'h0, resetn = 1'h0, sync_select = 1'h0, enc_8b10b = 1'h1, req = 1'h0, power_down_pin = 1'h0;
  logic se_n, ts_n, analog_enable;
  slsc_pkg::slsc_status_s status;
  int errors = 0, tests_run = 0;
  slsc_rx_model i_slsc_rx_model (.sel(sync_select), .req(req), .se_n(se_n), .ts_n(ts_n));
  slsc_top #(.ILAS_LEN(8'h04)) i_slsc_top (.clock(clock), .resetn(resetn), .sync_select(sync_select),
    .enc_8b10b(enc_8b10b), .single_ended_sync_request_n(se_n), .timestamp_diff_pair_sync_n(ts_n),
    .power_down_pin(power_down_pin), .status(status), .analog_enable(analog_enable));
  initial begin
    forever #50 clock = ~clock;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic check(input slsc_pkg::slsc_status_s exp, input logic an);
    #1;
    tests_run++;
    if (status !== exp || analog_enable !== an) begin
      errors++;
      $display("wrong value at %0t: status %b analog %b", $time, status, analog_enable);
    end
  endtask
  task automatic conclude;
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    tick(4);
    check(4'h0, 1'h0);
    @(posedge clock) resetn <= 1'h1;
    tick(1);
    check(4'h1, 1'h1);
  endtask
  task automatic t_link(input logic sel);
    @(posedge clock) sync_select <= sel;
    @(posedge clock) req <= 1'h1;
    tick(2);
    check(4'h1, 1'h1);
    tick(1);
    check(4'h9, 1'h1);
    @(posedge clock) req <= 1'h0;
    tick(3);
    check(4'h5, 1'h1);
    tick(3);
    check(4'h5, 1'h1);
    tick(1);
    check(4'h3, 1'h1);
  endtask
  task automatic t_pd;
    @(posedge clock) power_down_pin <= 1'h1;
    tick(2);
    check(4'h3, 1'h1);
    tick(1);
    check(4'h0, 1'h0);
    @(posedge clock) req <= 1'h1;
    tick(4);
    check(4'h0, 1'h0);
    @(posedge clock) req <= 1'h0;
    power_down_pin <= 1'h0;
    tick(3);
    check(4'h1, 1'h1);
  endtask
  task automatic t_mode;
    @(posedge clock) enc_8b10b <= 1'h0;
    req <= 1'h1;
    tick(4);
    check(4'h1, 1'h1);
    @(posedge clock) enc_8b10b <= 1'h1;
    tick(3);
    check(4'h9, 1'h1);
    @(posedge clock) req <= 1'h0;
    tick(8);
    check(4'h3, 1'h1);
    @(posedge clock) req <= 1'h1;
    tick(3);
    check(4'h9, 1'h1);
  endtask
  task automatic t_midreset;
    @(posedge clock) resetn <= 1'h0;
    tick(2);
    check(4'h0, 1'h0);
    @(posedge clock) resetn <= 1'h1;
    tick(1);
    check(4'h1, 1'h1);
    tick(2);
    check(4'h9, 1'h1);
  endtask
  initial begin
    t_reset();
    t_link(1'h0);
    t_pd();
    t_link(1'h1);
    t_mode();
    t_midreset();
    conclude();
  end
endmodule
`default_nettype wire
